// file: core/dual_serial_pin_logic.sv
// pin logic of the shared two-wire / four-wire serial port and limit alert
//
// Summary of operation
// - The bus address is 1001 000, 1001 010 or 1001 011 for a low, floating or high strap.
// - The strap address is not captured before the master has sent it twice.
// - Capture happens on the eighth clock rise of the second matching address frame.
// - After capture the strap input is ignored.
// - In four-wire mode read data leaves on every falling serial clock edge.
// - In four-wire mode write data from the master is sampled on every rising edge.
// - Any exceeded limit asserts the alert, whose active level can be high or low.
// - The alert is active low by default and only ever pulls the pin low.
// - Round robin visits every channel in fixed order, one measurement each.
// - Four-wire mode stays locked once chosen until the next power-up reset.
`timescale 1ns/1ps
module dual_serial_pin_logic (
  // system clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  // serial clock pin, also the link clock
  input  wire logic       ser_clk_i,
  // serial data in pin and chip select
  input  wire logic       ser_data_i,
  input  wire logic       chip_sel_n_i,
  // address strap sense: level and float detect
  input  wire logic       strap_high_i,
  input  wire logic       strap_float_i,
  // strap pin used as serial data out (open drain)
  output logic            strap_dout_o,
  output logic            strap_dout_oe_o,
  // limit events and alert configuration
  input  wire logic       limit_temp_i,
  input  wire logic       limit_supply_i,
  input  wire logic       limit_analog_i,
  input  wire logic       alert_active_high_i,
  // alert pin (open drain)
  output logic            alert_o,
  output logic            alert_oe_o,
  // measurement sequencing
  input  wire logic       monitor_en_i,
  input  wire logic       conv_done_i,
  output logic [3:0]      chan_o,
  output logic            conv_start_o,
  // user side of the four-wire data path
  input  wire logic [7:0] tx_byte_i,
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o,
  // protocol and address state
  output logic            four_wire_o,
  output logic [6:0]      bus_addr_o,
  output logic            addr_locked_o
);

  // ----------------------------------------------------------------
  // pin synchronisers in the system domain
  // ----------------------------------------------------------------
  logic [4:0] pins_sync;
  logic       scl_s;
  logic       sda_s;
  logic       cs_n_s;
  logic       strap_hi_s;
  logic       strap_fl_s;

  level_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .clk_i   (sys_clk_i),
    .nrst_i  (nrst_i),
    .async_i ({ser_clk_i, ser_data_i, chip_sel_n_i, strap_high_i, strap_float_i}),
    .sync_o  (pins_sync)
  );

  assign {scl_s, sda_s, cs_n_s, strap_hi_s, strap_fl_s} = pins_sync;

  // previous values for edge detection
  logic scl_d;
  logic sda_d;
  logic cs_n_d;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scl_d  <= 1'b0;
      sda_d  <= 1'b0;
      cs_n_d <= 1'b0;
    end
    else
    begin
      scl_d  <= scl_s;
      sda_d  <= sda_s;
      cs_n_d <= cs_n_s;
    end
  end

  logic scl_rise;
  logic bus_start;
  logic bus_stop;
  logic cs_fall;

  assign scl_rise  = scl_s & ~scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
  assign cs_fall   = cs_n_d & ~cs_n_s;

  // ----------------------------------------------------------------
  // protocol selection
  // ----------------------------------------------------------------
  // a chip select fall picks four-wire mode; only reset clears it
  // locked four-wire
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      four_wire_o <= 1'b0;
    else if (cs_fall)
      four_wire_o <= 1'b1;
  end

  // ----------------------------------------------------------------
  // two-wire address selection and latch
  // ----------------------------------------------------------------
  // strap decode, float has priority over the level
  // strap address table
  logic [6:0] strap_addr;

  always_comb
  begin
    if (strap_fl_s)
      strap_addr = serial_pin_pkg::ADDR_STRAP_FLOAT;
    else if (strap_hi_s)
      strap_addr = serial_pin_pkg::ADDR_STRAP_HIGH;
    else
      strap_addr = serial_pin_pkg::ADDR_STRAP_LOW;
  end

  logic [3:0] scl_cnt;    // clock rises since start
  logic [6:0] addr_shift; // address bits received
  logic       in_frame;

  // frame tracking on the two-wire bus
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      in_frame   <= 1'b0;
      scl_cnt    <= serial_pin_pkg::BIT_CNT_ZERO;
      addr_shift <= '0;
    end
    else if (four_wire_o)
      in_frame <= 1'b0;     // two-wire decoding off
    else if (bus_start)
    begin
      in_frame   <= 1'b1;
      scl_cnt    <= serial_pin_pkg::BIT_CNT_ZERO;
      addr_shift <= '0;
    end
    else if (bus_stop)
      in_frame <= 1'b0;
    else if (in_frame && scl_rise && scl_cnt < serial_pin_pkg::ADDR_LATCH_EDGE)
    begin
      scl_cnt <= scl_cnt + serial_pin_pkg::BIT_CNT_ONE;
      if (scl_cnt < serial_pin_pkg::ADDR_LATCH_EDGE - serial_pin_pkg::BIT_CNT_ONE)
        addr_shift <= {addr_shift[5:0], sda_s};
    end
  end

  // eighth rise of an address frame addressed to the strap value
  logic addr_match_edge;
  logic [1:0] seen_cnt;

  assign addr_match_edge = in_frame && scl_rise && !four_wire_o
                           && (scl_cnt == serial_pin_pkg::ADDR_LATCH_EDGE
                                          - serial_pin_pkg::BIT_CNT_ONE)
                           && (addr_shift == strap_addr);

  // count matching frames, latch on the second
  // two sends first
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      seen_cnt      <= '0;
      addr_locked_o <= 1'b0;
      bus_addr_o    <= serial_pin_pkg::ADDR_STRAP_LOW;
    end
    else if (!addr_locked_o)
    begin
      bus_addr_o <= strap_addr; // follows strap until locked
      if (addr_match_edge)
      begin
        seen_cnt <= seen_cnt + 2'h1;
        if (seen_cnt + 2'h1 == serial_pin_pkg::ADDR_SEEN_NEED)
          addr_locked_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // four-wire link domain, clocked by the serial clock
  // ----------------------------------------------------------------
  logic       four_wire_l;
  logic       frame_rst_n;
  logic [2:0] rx_cnt;
  logic [7:0] rx_shift;
  logic [7:0] rx_hold;
  logic       rx_tgl;
  logic [2:0] tx_cnt;
  logic [7:0] tx_shift;
  logic [7:0] tx_hold;

  // mode level into the link domain
  level_sync #(
    .WIDTH (1)
  ) u_mode_sync (
    .clk_i   (ser_clk_i),
    .nrst_i  (nrst_i),
    .async_i (four_wire_o),
    .sync_o  (four_wire_l)
  );

  // the frame ends by chip select, not by a clock edge
  // chip select frames
  assign frame_rst_n = nrst_i & ~chip_sel_n_i;

  // sample data in on rising edges
  // rising edge sample
  always_ff @(posedge ser_clk_i or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      rx_cnt   <= serial_pin_pkg::SHIFT_FIRST;
      rx_shift <= '0;
    end
    else if (four_wire_l)
    begin
      rx_cnt   <= rx_cnt + serial_pin_pkg::SHIFT_STEP;
      rx_shift <= {rx_shift[6:0], ser_data_i};
    end
  end

  // whole byte handed over with a toggle; hold stays until next byte
  always_ff @(posedge ser_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_hold <= '0;
      rx_tgl  <= 1'b0;
    end
    else if (four_wire_l && !chip_sel_n_i && rx_cnt == serial_pin_pkg::SHIFT_LAST)
    begin
      rx_hold <= {rx_shift[6:0], ser_data_i};
      rx_tgl  <= ~rx_tgl;
    end
  end

  // shift read data out on falling edges, msb first
  // falling edge shift
  always_ff @(negedge ser_clk_i or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      tx_cnt          <= serial_pin_pkg::SHIFT_FIRST;
      tx_shift        <= '0;
      strap_dout_oe_o <= 1'b0;
    end
    else if (four_wire_l)
    begin
      tx_cnt <= tx_cnt + serial_pin_pkg::SHIFT_STEP;
      if (tx_cnt == serial_pin_pkg::SHIFT_FIRST)
      begin
        tx_shift        <= {tx_hold[6:0], 1'b0};
        strap_dout_oe_o <= ~tx_hold[serial_pin_pkg::BYTE_BITS-1];
      end
      else
      begin
        tx_shift        <= {tx_shift[6:0], 1'b0};
        strap_dout_oe_o <= ~tx_shift[serial_pin_pkg::BYTE_BITS-1];
      end
    end
    else
      strap_dout_oe_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // link to system crossing of received bytes
  // ----------------------------------------------------------------
  logic rx_tgl_s;
  logic rx_tgl_d;

  level_sync #(
    .WIDTH (1)
  ) u_rx_sync (
    .clk_i   (sys_clk_i),
    .nrst_i  (nrst_i),
    .async_i (rx_tgl),
    .sync_o  (rx_tgl_s)
  );

  // capture the stable hold register once the toggle arrives
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_tgl_d   <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_byte_o  <= '0;
    end
    else
    begin
      rx_tgl_d   <= rx_tgl_s;
      rx_valid_o <= rx_tgl_s ^ rx_tgl_d;
      if (rx_tgl_s ^ rx_tgl_d)
        rx_byte_o <= rx_hold;
    end
  end

  // read data word, taken only while no frame is open
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tx_hold <= '0;
    else if (cs_n_s)
      tx_hold <= tx_byte_i;
  end

  // open-drain data pin never drives high
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      strap_dout_o <= 1'b0;
    else
      strap_dout_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // overlimit alert
  // ----------------------------------------------------------------
  logic limit_any;

  assign limit_any = limit_temp_i | limit_supply_i | limit_analog_i;

  // pull low when asserted active low, or when idle active high
  // alert on limit
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      alert_o    <= 1'b0;
      alert_oe_o <= 1'b0;
    end
    else
    begin
      alert_o    <= 1'b0;
      alert_oe_o <= limit_any ^ alert_active_high_i;
    end
  end

  // ----------------------------------------------------------------
  // round-robin channel sequencer
  // ----------------------------------------------------------------
  serial_pin_pkg::rr_state_t rr_state;

  // one start per channel, advance on done, wrap after the last
  // fixed channel order
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rr_state     <= serial_pin_pkg::RR_IDLE;
      chan_o       <= serial_pin_pkg::CHAN_SUPPLY;
      conv_start_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= 1'b0;
      case (rr_state)
        serial_pin_pkg::RR_IDLE:
        begin
          chan_o <= serial_pin_pkg::CHAN_SUPPLY;
          if (monitor_en_i)
            rr_state <= serial_pin_pkg::RR_START;
        end
        serial_pin_pkg::RR_START:
        begin
          conv_start_o <= 1'b1;
          rr_state     <= serial_pin_pkg::RR_WAIT;
        end
        serial_pin_pkg::RR_WAIT:
        begin
          if (conv_done_i)
          begin
            if (chan_o == serial_pin_pkg::CHAN_LAST)
              chan_o <= serial_pin_pkg::CHAN_SUPPLY;
            else
              chan_o <= chan_o + serial_pin_pkg::CHAN_STEP;
            rr_state <= monitor_en_i ? serial_pin_pkg::RR_START
                                     : serial_pin_pkg::RR_IDLE;
          end
        end
        default:
          rr_state <= serial_pin_pkg::RR_IDLE;
      endcase
    end
  end

endmodule

// file: core/level_sync.sv
// two flip-flop synchroniser for level signals
`timescale 1ns/1ps
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset of the receiving domain
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

// file: dv/dual_serial_pin_logic_monitor.sv
// assertion checker on the ports of the serial pin logic
`timescale 1ns/1ps
module dual_serial_pin_logic_monitor (
  // clock, reset and pins
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  input wire logic       chip_sel_n_i,
  input wire logic       strap_high_i,
  input wire logic       strap_float_i,
  input wire logic       strap_dout_o,
  input wire logic       strap_dout_oe_o,
  // limits and alert
  input wire logic       limit_temp_i,
  input wire logic       limit_supply_i,
  input wire logic       limit_analog_i,
  input wire logic       alert_active_high_i,
  input wire logic       alert_o,
  input wire logic       alert_oe_o,
  // sequencing and status
  input wire logic [3:0] chan_o,
  input wire logic       conv_start_o,
  input wire logic       rx_valid_o,
  input wire logic       four_wire_o,
  input wire logic [6:0] bus_addr_o,
  input wire logic       addr_locked_o
);
  logic any_lim;

  // any exceeded limit
  assign any_lim = limit_temp_i | limit_supply_i | limit_analog_i;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------------------------------
  // address, mode and pins
  // ----------------------------------------------------------------
  a_addr_low: assert property ((!addr_locked_o && !strap_float_i && !strap_high_i)[*4]
    |=> bus_addr_o == serial_pin_pkg::ADDR_STRAP_LOW) else $error("low strap address wrong");
  a_addr_float: assert property ((!addr_locked_o && strap_float_i)[*4]
    |=> bus_addr_o == serial_pin_pkg::ADDR_STRAP_FLOAT) else $error("float address wrong");
  a_addr_high: assert property ((!addr_locked_o && !strap_float_i && strap_high_i)[*4]
    |=> bus_addr_o == serial_pin_pkg::ADDR_STRAP_HIGH) else $error("high strap address wrong");
  a_addr_frozen: assert property (addr_locked_o
    |=> addr_locked_o && $stable(bus_addr_o)) else $error("latched address moved");
  a_mode_kept: assert property (four_wire_o |=> four_wire_o)
    else $error("four-wire mode dropped");
  a_dout_two_wire: assert property (!four_wire_o |-> !strap_dout_oe_o)
    else $error("strap pin driven in two-wire mode");
  a_dout_deselect: assert property (chip_sel_n_i[*2] |-> !strap_dout_oe_o)
    else $error("data out driven while deselected");

  // ----------------------------------------------------------------
  // alert and sequencing
  // ----------------------------------------------------------------
  a_alert_level: assert property (1'b1 |=> alert_oe_o ==
    ($past(any_lim) ^ $past(alert_active_high_i))) else $error("alert level wrong");
  a_open_drain: assert property (alert_o == 1'b0 && strap_dout_o == 1'b0)
    else $error("open drain pin driven high");
  a_conv_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  a_chan_order: assert property (chan_o <= serial_pin_pkg::CHAN_LAST &&
    (!$changed(chan_o) || chan_o == $past(chan_o) + serial_pin_pkg::CHAN_STEP
    || chan_o == serial_pin_pkg::CHAN_SUPPLY)) else $error("channel order broken");
  a_rx_pulse: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("receive pulse too long");

  c_lock: cover property ($rose(addr_locked_o));
  c_mode: cover property ($rose(four_wire_o));
  c_wrap: cover property (chan_o == serial_pin_pkg::CHAN_LAST && conv_start_o);
  c_rx: cover property ($rose(rx_valid_o));
endmodule

bind dual_serial_pin_logic dual_serial_pin_logic_monitor u_monitor (
  .sys_clk_i           (sys_clk_i),
  .nrst_i              (nrst_i),
  .chip_sel_n_i        (chip_sel_n_i),
  .strap_high_i        (strap_high_i),
  .strap_float_i       (strap_float_i),
  .strap_dout_o        (strap_dout_o),
  .strap_dout_oe_o     (strap_dout_oe_o),
  .limit_temp_i        (limit_temp_i),
  .limit_supply_i      (limit_supply_i),
  .limit_analog_i      (limit_analog_i),
  .alert_active_high_i (alert_active_high_i),
  .alert_o             (alert_o),
  .alert_oe_o          (alert_oe_o),
  .chan_o              (chan_o),
  .conv_start_o        (conv_start_o),
  .rx_valid_o          (rx_valid_o),
  .four_wire_o         (four_wire_o),
  .bus_addr_o          (bus_addr_o),
  .addr_locked_o       (addr_locked_o)
);

// file: dv/dual_serial_pin_logic_test.sv
// self-checking bench for the dual serial pin logic
`timescale 1ns/1ps
module dual_serial_pin_logic_test;
  logic       sys_clk;
  logic       nrst;
  logic       ser_clk;
  logic       ser_data;
  logic       cs_n;
  logic       s_high;
  logic       s_float;
  logic       dout;
  logic       dout_oe;
  logic       lim_t;
  logic       lim_s;
  logic       lim_a;
  logic       pol;
  logic       alert;
  logic       alert_oe;
  logic       mon_en;
  logic       conv_done;
  logic [3:0] chan;
  logic       conv_start;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       four_wire;
  logic [6:0] bus_addr;
  logic       locked;
  logic       dout_line;
  int         err_count;
  int         checked;
  int         rx_cnt;

  // pull-up on the open-drain data out
  assign dout_line = dout_oe ? 1'b0 : 1'b1;

  dual_serial_pin_logic u_dut (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
    .chip_sel_n_i(cs_n), .strap_high_i(s_high), .strap_float_i(s_float),
    .strap_dout_o(dout), .strap_dout_oe_o(dout_oe), .limit_temp_i(lim_t),
    .limit_supply_i(lim_s), .limit_analog_i(lim_a), .alert_active_high_i(pol),
    .alert_o(alert), .alert_oe_o(alert_oe), .monitor_en_i(mon_en), .conv_done_i(conv_done),
    .chan_o(chan), .conv_start_o(conv_start), .tx_byte_i(tx_byte), .rx_byte_o(rx_byte),
    .rx_valid_o(rx_valid), .four_wire_o(four_wire), .bus_addr_o(bus_addr),
    .addr_locked_o(locked));

  serial_host_model u_host (.sys_clk_i(sys_clk), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
    .chip_sel_n_o(cs_n), .dout_line_i(dout_line));

  // system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // count received byte pulses
  always @(posedge sys_clk)
    if (rx_valid === 1'b1)
      rx_cnt++;

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic t_strap;
    logic [6:0] exp [4];
    logic [1:0] sel [4];
    exp = '{serial_pin_pkg::ADDR_STRAP_LOW, serial_pin_pkg::ADDR_STRAP_FLOAT,
            serial_pin_pkg::ADDR_STRAP_HIGH, serial_pin_pkg::ADDR_STRAP_FLOAT};
    sel = '{2'h0, 2'h2, 2'h1, 2'h3};
    for (int i = 0; i < 4; i++)
    begin
      {s_float, s_high} = sel[i];
      tick(5);
      chk(bus_addr === exp[i], "strap address");
    end
    $display("test strap done");
  endtask

  task automatic t_alert;
    for (int k = 0; k < 16; k++)
    begin
      {pol, lim_t, lim_s, lim_a} = 4'(k);
      tick(2);
      chk(alert_oe === ((lim_t | lim_s | lim_a) ^ pol), "alert level");
      chk(alert === 1'b0, "alert drives high");
    end
    {pol, lim_t, lim_s, lim_a} = 4'h0;
    $display("test alert done");
  endtask

  task automatic t_round;
    int n;
    mon_en = 1'b1;
    for (int k = 0; k < 10; k++)
    begin
      n = 0;
      while (conv_start !== 1'b1 && n < 20)
      begin
        tick(1);
        n++;
      end
      chk(n < 20, "no start pulse");
      chk(chan === 4'(k % 9), "channel order");
      if (k == 9)
        mon_en = 1'b0;
      conv_done = 1'b1;
      tick(1);
      conv_done = 1'b0;
    end
    tick(4);
    chk(chan === serial_pin_pkg::CHAN_SUPPLY, "idle channel");
    $display("test round done");
  endtask

  task automatic t_latch;
    s_high  = 1'b1;
    s_float = 1'b0;
    tick(5);
    u_host.addr_frame(serial_pin_pkg::ADDR_STRAP_HIGH);
    chk(locked === 1'b0, "lock after one frame");
    u_host.addr_frame(serial_pin_pkg::ADDR_STRAP_LOW);
    chk(locked === 1'b0, "lock on foreign address");
    u_host.addr_frame(serial_pin_pkg::ADDR_STRAP_HIGH);
    chk(locked === 1'b1, "no lock after second frame");
    s_high = 1'b0;
    tick(6);
    chk(bus_addr === serial_pin_pkg::ADDR_STRAP_HIGH, "strap not ignored");
    $display("test latch done");
  endtask

  task automatic t_spi;
    logic [7:0] q;
    int         c0;
    tx_byte = 8'h3C;
    u_host.spi_byte(8'h00, q);
    chk(four_wire === 1'b1, "mode not selected");
    c0 = rx_cnt;
    u_host.spi_byte(8'hA5, q);
    chk(rx_cnt == c0 + 1, "receive pulse count");
    chk(rx_byte === 8'hA5, "write data");
    chk(q === 8'h3C, "read data");
    chk(dout === 1'b0, "data pin drives high");
    chk(dout_oe === 1'b0, "data pin held after frame");
    chk(four_wire === 1'b1, "mode dropped");
    $display("test four-wire done");
  endtask

  task automatic t_relock;
    nrst = 1'b0;
    tick(6);
    nrst = 1'b1;
    tick(3);
    chk(four_wire === 1'b0, "mode after power cycle");
    chk(locked === 1'b0, "lock after power cycle");
    $display("test power cycle done");
  endtask

  // watchdog
  initial
  begin
    #1000000;
    err_count++;
    $display("mismatch at %0t: watchdog", $time);
    close_out;
  end

  // main sequence
  initial
  begin
    nrst      = 1'b0;
    s_high    = 1'b0;
    s_float   = 1'b0;
    {pol, lim_t, lim_s, lim_a} = 4'h0;
    mon_en    = 1'b0;
    conv_done = 1'b0;
    tx_byte   = 8'h00;
    tick(6);
    chk(bus_addr === serial_pin_pkg::ADDR_STRAP_LOW, "reset address");
    nrst = 1'b1;
    tick(3);
    t_strap;
    t_alert;
    t_round;
    t_latch;
    t_spi;
    t_relock;
    close_out;
  end
endmodule

// file: dv/serial_host_model.sv
// host master model: two-wire address frames and four-wire bytes
`timescale 1ns/1ps
module serial_host_model (
  // pacing clock
  input  wire logic sys_clk_i,
  // pins toward the device
  output logic      ser_clk_o,
  output logic      ser_data_o,
  output logic      chip_sel_n_o,
  input  wire logic dout_line_i
);
  // lines released and pulled up
  initial
  begin
    ser_clk_o    = 1'b1;
    ser_data_o   = 1'b1;
    chip_sel_n_o = 1'b1;
  end

  // spacing of two-wire edges
  task automatic step;
    repeat (4) @(posedge sys_clk_i);
    #2;
  endtask

  // start, seven address bits msb first, write bit, stop
  task automatic addr_frame(input logic [6:0] addr);
    logic [7:0] bits;
    bits       = {addr, 1'b0};
    ser_data_o = 1'b0;
    step;
    for (int i = 7; i >= 0; i--)
    begin
      ser_clk_o  = 1'b0;
      step;
      ser_data_o = bits[i];
      step;
      ser_clk_o  = 1'b1;
      step;
    end
    ser_clk_o  = 1'b0;
    step;
    ser_data_o = 1'b0;
    step;
    ser_clk_o  = 1'b1;
    step;
    ser_data_o = 1'b1;
    step;
  endtask

  task automatic spi_byte(input logic [7:0] d, output logic [7:0] q);
    chip_sel_n_o = 1'b0;
    step;
    #1.7;
    for (int i = 7; i >= 0; i--)
    begin
      ser_clk_o  = 1'b0;
      ser_data_o = d[i];
      #3;
      ser_clk_o  = 1'b1;
      q[i]       = dout_line_i;
      #3;
    end
    step;
    chip_sel_n_o = 1'b1;
    ser_data_o   = 1'b1;
    step;
  endtask
endmodule

// file: inc/serial_pin_pkg.sv
// constants shared by the serial pin logic
package serial_pin_pkg;

  // ----------------------------------------------------------------
  // two-wire bus addresses selected by the three-state strap
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_STRAP_LOW   = 7'h48; // 1001 000
  localparam logic [6:0] ADDR_STRAP_FLOAT = 7'h4A; // 1001 010
  localparam logic [6:0] ADDR_STRAP_HIGH  = 7'h4B; // 1001 011
  localparam int unsigned ADDR_W          = 7;

  // ----------------------------------------------------------------
  // address latch sequencing
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_SEEN_NEED   = 2'h2; // matching frames before latch
  localparam logic [3:0] ADDR_LATCH_EDGE  = 4'h8; // scl rise that latches
  localparam logic [3:0] BIT_CNT_ZERO     = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE      = 4'h1;

  // ----------------------------------------------------------------
  // four-wire shifting
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_BITS       = 8;
  localparam logic [2:0] SHIFT_LAST       = 3'h7;
  localparam logic [2:0] SHIFT_FIRST      = 3'h0;
  localparam logic [2:0] SHIFT_STEP       = 3'h1;

  // ----------------------------------------------------------------
  // round-robin measurement channels, in visiting order
  // ----------------------------------------------------------------
  localparam int unsigned CHAN_W          = 4;
  localparam logic [3:0] CHAN_SUPPLY      = 4'h0;
  localparam logic [3:0] CHAN_INT_TEMP    = 4'h1;
  localparam logic [3:0] CHAN_EXT_TEMP    = 4'h2;
  localparam logic [3:0] CHAN_LAST        = 4'h8; // analog_channel_in 8
  localparam logic [3:0] CHAN_STEP        = 4'h1;

  // round-robin sequencer states
  typedef enum logic [1:0] {RR_IDLE, RR_START, RR_WAIT} rr_state_t;

endpackage
